/* include/msr_dp_if.sv */
// datapath signals between the stage top and its rounder and limiter
`timescale 1ns/1ps
interface msr_dp_if;
  import msr_pkg::*;

  logic [ACC_W-1:0] rnd_in;
  logic             rnd_en;
  msr_rnd_mode_t    rnd_mode;
  logic             rnd_clear_low;
  logic [ACC_W-1:0] rnd_out;
  logic             sat_en;
  logic [ACC_W-1:0] sat_out;
  logic             sat_hit;
  logic             sat_neg;

  modport top_mp (
    output rnd_in, rnd_en, rnd_mode, rnd_clear_low, sat_en,
    input  rnd_out, sat_out, sat_hit, sat_neg
  );
  modport rnd_mp (
    input  rnd_in, rnd_en, rnd_mode, rnd_clear_low,
    output rnd_out
  );
  modport sat_mp (
    input  rnd_out, sat_en,
    output sat_out, sat_hit, sat_neg
  );
endinterface : msr_dp_if

/* include/msr_pkg.sv */
// constants, types and helpers shared by the saturation and rounding stage
package msr_pkg;

  // data widths
  localparam int unsigned ACC_W      = 36;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned CLASS_W    = 4;

  // bit positions examined by the limiter
  localparam int unsigned EXT3_POS   = 35;
  localparam int unsigned EXT0_POS   = 32;
  localparam int unsigned MSP15_POS  = 31;

  // rounding point sits between these two bits
  localparam int unsigned RND_HI_POS = 16;
  localparam int unsigned RND_LO_POS = 15;

  // saturation extremes
  localparam logic [ACC_W-1:0]  SAT_POS_VAL = 36'h0_7FFF_FFFF;
  localparam logic [ACC_W-1:0]  SAT_NEG_VAL = 36'hF_8000_0000;

  // one half of the low word, and the cleared low word
  localparam logic [WORD_W-1:0] LOW_HALF    = 16'h8000;
  localparam logic [WORD_W-1:0] LOW_CLEARED = 16'h0000;

  // increment applied to the upper 20 bits when rounding up
  localparam logic [ACC_W-RND_HI_POS-1:0] RND_INC = 20'h00001;

  // rounding mode encoding of the mode bit
  typedef enum logic {
    MSR_RND_CONV = 1'b0,
    MSR_RND_TWOS = 1'b1
  } msr_rnd_mode_t;

  // value after reset of the rounding mode and enable
  localparam msr_rnd_mode_t RND_MODE_RESET = MSR_RND_CONV;
  localparam logic          SAT_EN_RESET   = 1'b0;

  // instruction class reported by the decoder
  typedef enum logic [CLASS_W-1:0] {
    MSR_CLS_ARITH      = 4'h0,
    MSR_CLS_RND        = 4'h1,
    MSR_CLS_MPY_RND    = 4'h2,
    MSR_CLS_MAC_RND    = 4'h3,
    MSR_CLS_XFER       = 4'h4,
    MSR_CLS_CMP        = 4'h5,
    MSR_CLS_MBIT_SHIFT = 4'h6,
    MSR_CLS_ACC_SHIFT  = 4'h7,
    MSR_CLS_INT_MPY    = 4'h8,
    MSR_CLS_SU_MPY     = 4'h9,
    MSR_CLS_LOGIC      = 4'hA,
    MSR_CLS_SBIT_SHIFT = 4'hB,
    MSR_CLS_ROTATE     = 4'hC,
    MSR_CLS_NOT        = 4'hD,
    MSR_CLS_TEST       = 4'hE,
    MSR_CLS_NON_ALU    = 4'hF
  } msr_class_t;

  // true for classes whose result may be limited
  function automatic logic msr_sat_allowed(input msr_class_t cls);
    case (cls)
      MSR_CLS_ARITH, MSR_CLS_RND, MSR_CLS_MPY_RND,
      MSR_CLS_MAC_RND, MSR_CLS_XFER: msr_sat_allowed = 1'b1;
      default:                       msr_sat_allowed = 1'b0;
    endcase
  endfunction : msr_sat_allowed

  // true for the three rounding classes
  function automatic logic msr_is_round(input msr_class_t cls);
    case (cls)
      MSR_CLS_RND, MSR_CLS_MPY_RND, MSR_CLS_MAC_RND: msr_is_round = 1'b1;
      default:                                       msr_is_round = 1'b0;
    endcase
  endfunction : msr_is_round

endpackage : msr_pkg

/* logic/msr_limiter.sv */
// output limiter on the 36-bit result
`timescale 1ns/1ps
module msr_limiter
  import msr_pkg::*;
(
  // datapath
  msr_dp_if.sat_mp dp
);

  logic ext3;
  logic ext0;
  logic msp15;
  logic go_pos;
  logic go_neg;

  always_comb begin
    ext3   = dp.rnd_out[EXT3_POS];
    ext0   = dp.rnd_out[EXT0_POS];
    msp15  = dp.rnd_out[MSP15_POS];
    go_pos = dp.sat_en && !ext3 && (ext0 || msp15);
    go_neg = dp.sat_en && ext3 && !(ext0 && msp15);
  end

  always_comb begin
    if (go_pos) begin
      dp.sat_out = SAT_POS_VAL;
    end else if (go_neg) begin
      dp.sat_out = SAT_NEG_VAL;
    end else begin
      dp.sat_out = dp.rnd_out;
    end
    dp.sat_hit = go_pos || go_neg;
    dp.sat_neg = go_neg;
  end

endmodule : msr_limiter

/* logic/msr_rounder.sv */
// single-precision rounder, convergent or two's complement
`timescale 1ns/1ps
module msr_rounder
  import msr_pkg::*;
(
  // datapath
  msr_dp_if.rnd_mp dp
);

  logic [WORD_W-1:0]             low_word;
  logic [ACC_W-RND_HI_POS-1:0]   upper;
  logic [ACC_W-RND_HI_POS-1:0]   upper_sum;
  logic                          round_up;

  // rounding decision at the point between bit 16 and bit 15
  always_comb begin
    low_word = dp.rnd_in[WORD_W-1:0];
    upper    = dp.rnd_in[ACC_W-1:RND_HI_POS];
    round_up = 1'b0;
    if (dp.rnd_mode == MSR_RND_TWOS) begin
      round_up = dp.rnd_in[RND_LO_POS];
    end else begin
      if (low_word > LOW_HALF) begin
        round_up = 1'b1;
      end else if (low_word == LOW_HALF) begin
        round_up = dp.rnd_in[RND_HI_POS];
      end
    end
    // wraps at 36 bits; the limiter catches the overflow afterwards
    upper_sum = round_up ? upper + RND_INC : upper;
  end

  // pass through when not rounding
  always_comb begin
    if (!dp.rnd_en) begin
      dp.rnd_out = dp.rnd_in;
    end else if (dp.rnd_clear_low) begin
      dp.rnd_out = {upper_sum, LOW_CLEARED};
    end else begin
      dp.rnd_out = {upper_sum, low_word};
    end
  end

endmodule : msr_rounder

/* logic/msr_stage.sv */
// saturation and rounding stage between the multiply array and write-back
//
// How it works
// - limit arithmetic results only while the saturation enable bit is set
// - limiter looks at extension bit 3, extension bit 0, upper bit 15
// - ext3 clear with ext0 or msp15 set gives 0_7FFF_FFFF
// - ext3 set without both ext0 and msp15 gives F_8000_0000
// - all three bits equal: array result passes unchanged
// - limited value is written back to the destination accumulator
// - shifts, integer and mixed multiplies, logic, rotate, not, test never limit
// - compare: enable only affects unnormalized flag for memory/immediate vs input reg
// - non data-ALU instructions are not touched by the limiter
// - accumulator transfers are limited while the enable bit is set
// - limiter outcome is exported so flag logic can use it
// - three rounding classes round to single precision, clear low word for accumulators
// - rounding point sits between bit 16 and bit 15
// - rounding select bit chooses convergent or two's complement
// - convergent rounding after reset
// - convergent: above half up, below down, exact half follows bit 16
// - two's complement: add one at bit 15 then truncate
// - a changed rounding select bit applies one instruction later
`timescale 1ns/1ps
module msr_stage
  import msr_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               resetn,
  // operating mode bits
  input  wire logic               saturation_enable_bit,
  input  wire logic               round_select_bit,
  // instruction from the decoder
  input  wire logic               instr_valid,
  input  wire logic [CLASS_W-1:0] instr_class,
  input  wire logic               dest_is_acc,
  input  wire logic               cmp_op1_mem_imm,
  input  wire logic               cmp_op2_input_reg,
  // operands
  input  wire logic [ACC_W-1:0]   array_result,
  input  wire logic [ACC_W-1:0]   xfer_source,
  // write-back and flag hints
  output logic                    wb_valid,
  output logic [ACC_W-1:0]        wb_data,
  output logic                    wb_limited,
  output logic                    wb_limited_neg,
  output logic                    cmp_unnorm_sa,
  output logic                    round_mode_active
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    msr_rnd_mode_t    mode_seen;    // select bit taken at the last instruction
    logic             valid;
    logic [ACC_W-1:0] data;
    logic             limited;
    logic             limited_neg;
    logic             cmp_sa;
  } msr_state_t;

  msr_state_t state_reg;
  msr_state_t state_next;

  msr_dp_if   dp ();

  msr_class_t cls;
  logic       limit_ok;
  logic       rounding;
  logic       is_cmp;

  ////////////////////////////////////////////////////////////////////////
  // class decode

  // classes not in the enum cannot occur: the encoding is full
  always_comb begin
    cls      = msr_class_t'(instr_class);
    limit_ok = msr_sat_allowed(cls);
    rounding = msr_is_round(cls);
    is_cmp   = (cls == MSR_CLS_CMP);
  end

  ////////////////////////////////////////////////////////////////////////
  // datapath drive

  // transfers take the other accumulator, all else takes the array
  always_comb begin
    dp.rnd_in        = (cls == MSR_CLS_XFER) ? xfer_source : array_result;
    dp.rnd_en        = rounding;
    dp.rnd_mode      = state_reg.mode_seen;
    dp.rnd_clear_low = dest_is_acc;
    dp.sat_en        = saturation_enable_bit && limit_ok;
  end

  msr_rounder u_rounder (
    .dp (dp.rnd_mp)
  );

  msr_limiter u_limiter (
    .dp (dp.sat_mp)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next       = state_reg;
    state_next.valid = instr_valid;
    if (instr_valid) begin
      // sample select bit
      // the sample is used by the next instruction, giving the delay
      state_next.mode_seen   = msr_rnd_mode_t'(round_select_bit);
      state_next.data        = dp.sat_out;
      state_next.limited     = dp.sat_hit;
      state_next.limited_neg = dp.sat_neg;
      state_next.cmp_sa      = is_cmp && saturation_enable_bit
                               && cmp_op1_mem_imm && cmp_op2_input_reg;
    end else begin
      state_next.limited     = 1'b0;
      state_next.limited_neg = 1'b0;
      state_next.cmp_sa      = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg.mode_seen   <= RND_MODE_RESET;
      state_reg.valid       <= 1'b0;
      state_reg.data        <= '0;
      state_reg.limited     <= 1'b0;
      state_reg.limited_neg <= 1'b0;
      state_reg.cmp_sa      <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // all outputs come from the state register
  assign wb_valid          = state_reg.valid;
  assign wb_data           = state_reg.data;
  assign wb_limited        = state_reg.limited;
  assign wb_limited_neg    = state_reg.limited_neg;
  assign cmp_unnorm_sa     = state_reg.cmp_sa;
  assign round_mode_active = state_reg.mode_seen;

endmodule : msr_stage

/* sim/mac_saturation_and_rounding_bench.sv */
// self-checking bench for the saturation and rounding stage
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module mac_saturation_and_rounding_bench;
  import msr_pkg::*;
  logic clock, resetn, sat, rsel, iv, dacc, op1, op2, wbv, wbl, wbn, cus, rma, mode;
  logic [CLASS_W-1:0] cls;
  logic [ACC_W-1:0]   ar, xs, acc, wbd, v;
  logic [ACC_W+2:0]   expq[$];
  logic [15:0]        lw[4] = '{16'h7FFF, 16'h8000, 16'h8001, 16'h8000};
  int                 mismatches, comparisons;
  ////////////////////////////////////////
  msr_stage i_msr_stage (.clock(clock), .resetn(resetn), .saturation_enable_bit(sat),
    .round_select_bit(rsel), .instr_valid(iv), .instr_class(cls), .dest_is_acc(dacc),
    .cmp_op1_mem_imm(op1), .cmp_op2_input_reg(op2), .array_result(ar), .xfer_source(xs),
    .wb_valid(wbv), .wb_data(wbd), .wb_limited(wbl), .wb_limited_neg(wbn),
    .cmp_unnorm_sa(cus), .round_mode_active(rma));
  msr_acc_model i_msr_acc_model (.clock(clock), .resetn(resetn), .wb_valid(wbv),
    .wb_data(wbd), .acc(acc));
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // reference: round first, then limit, so a rounding carry can saturate
  function automatic logic [ACC_W+2:0] expect_of(input logic [CLASS_W-1:0] c,
      input logic s, m, d, o1, o2, input logic [ACC_W-1:0] a, x);
    logic [ACC_W-1:0] r;
    logic up, lim;
    r = (c == MSR_CLS_XFER) ? x : a;
    if (c inside {MSR_CLS_RND, MSR_CLS_MPY_RND, MSR_CLS_MAC_RND}) begin
      up = m ? r[15] : (r[15:0] > LOW_HALF || (r[15:0] == LOW_HALF && r[16]));
      r[35:16] = r[35:16] + {19'h0, up};
      if (d) r[15:0] = LOW_CLEARED;
    end
    lim = s && c <= MSR_CLS_XFER && !(r[35] == r[32] && r[32] == r[31]);
    if (lim) r = r[35] ? SAT_NEG_VAL : SAT_POS_VAL;
    return {r, lim, lim & r[35], c == MSR_CLS_CMP && s && o1 && o2};
  endfunction : expect_of
  // one instruction per call; calls in a row go back to back
  task automatic issue(input logic [CLASS_W-1:0] c, input logic s, r, d, o1, o2,
      input logic [ACC_W-1:0] a, x);
    @(negedge clock);
    {cls, sat, rsel, dacc, op1, op2, ar, xs, iv} = {c, s, r, d, o1, o2, a, x, 1'b1};
    expq.push_back(expect_of(c, s, mode, d, o1, o2, a, x));
    mode = r;
  endtask : issue
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clock);
      iv = 0;
    end
  endtask : idle
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // result watcher
  always @(negedge clock) begin
    if (wbv === 1'b1) begin
      if (expq.size() == 0) `CHK(wbv, 1'b0)
      else `CHK({wbd, wbl, wbn, cus}, expq.pop_front())
    end
  end
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
  ////////////////////////////////////////
  initial begin
    {sat, rsel, iv, dacc, op1, op2, cls, ar, xs} = '0;
    mode = 0;
    resetn = 0;
    void'($urandom(18));
    repeat (16) @(posedge clock);
    `CHK({wbv, wbl, wbn, cus, rma}, 5'h00)
    @(negedge clock) resetn = 1;
    for (int k = 0; k < 16; k++) begin
      v = 36'({$urandom, $urandom});
      {v[35], v[32], v[31]} = k[2:0];
      issue(MSR_CLS_ARITH, k[3], 0, 1, 0, 0, v, v);
    end
    idle(2);
    $display("test limiter table done");
    for (int k = 4; k < 20; k++) begin
      v = {4'h0, 1'b1, 31'($urandom)};
      // transfers see a zero array result so only the source word can saturate
      issue((k > 15) ? 4'h5 : k[3:0], 1, 0, 1, k[0], k[1], (k == 4) ? '0 : v, v);
    end
    idle(2);
    $display("test class gating done");
    // low words at and near one half
    for (int k = 0; k < 64; k++) begin
      v = 36'({$urandom, $urandom});
      v[16] = k[2];
      v[15:0] = lw[k[1:0]];
      issue(4'(1 + k % 3), k[5], k[3], k[4], 0, 0, v, v);
    end
    idle(2);
    $display("test rounding done");
    // increments fed back from the accumulator file
    issue(MSR_CLS_ARITH, 1, 0, 1, 0, 0, 36'h0_7FFC_0000, 36'h0);
    repeat (6) begin
      idle(2);
      issue(MSR_CLS_ARITH, 1, 0, 1, 0, 0, acc + 36'h0_0001_0000, 36'h0);
    end
    idle(2);
    `CHK(acc, SAT_POS_VAL)
    $display("test accumulate chain done");
    repeat (200) begin
      v = 36'({$urandom, $urandom});
      issue(4'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
        1'($urandom), v, {v[17:0], v[35:18]});
    end
    idle(4);
    $display("test random done");
    final_report();
  end
endmodule : mac_saturation_and_rounding_bench

/* sim/msr_acc_model.sv */
// accumulator file model catching write-back results
`timescale 1ns/1ps
module msr_acc_model
  import msr_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // write-back side
  input  wire logic             wb_valid,
  input  wire logic [ACC_W-1:0] wb_data,
  output logic      [ACC_W-1:0] acc
);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) acc <= '0;
    else if (wb_valid) acc <= wb_data;
  end
endmodule : msr_acc_model

/* sim/msr_stage_sva.sv */
// port assertions for the saturation and rounding stage
`timescale 1ns/1ps
module msr_stage_sva
  import msr_pkg::*;
(
  // clock and reset
  input wire logic               clock,
  input wire logic               resetn,
  // mode and instruction
  input wire logic               saturation_enable_bit,
  input wire logic               round_select_bit,
  input wire logic               instr_valid,
  input wire logic [CLASS_W-1:0] instr_class,
  input wire logic               dest_is_acc,
  input wire logic               cmp_op1_mem_imm,
  input wire logic               cmp_op2_input_reg,
  input wire logic [ACC_W-1:0]   array_result,
  input wire logic [ACC_W-1:0]   xfer_source,
  // results
  input wire logic               wb_valid,
  input wire logic [ACC_W-1:0]   wb_data,
  input wire logic               wb_limited,
  input wire logic               wb_limited_neg,
  input wire logic               cmp_unnorm_sa,
  input wire logic               round_mode_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // an arithmetic instruction taken with the limiter on
  sequence s_arith_on;
    instr_valid && saturation_enable_bit && instr_class == MSR_CLS_ARITH;
  endsequence
  sequence s_pos_ovf;
    s_arith_on ##0 (!array_result[35] && (array_result[32] || array_result[31]));
  endsequence
  sequence s_neg_ovf;
    s_arith_on ##0 (array_result[35] && !(array_result[32] && array_result[31]));
  endsequence
  take_answer_a: assert property (instr_valid |=> wb_valid)
    else $error("instruction not answered next cycle");
  idle_quiet_a: assert property (!instr_valid |=> !wb_valid && !wb_limited && !cmp_unnorm_sa)
    else $error("result flags without instruction");
  sat_pos_a: assert property (s_pos_ovf |=> wb_limited && wb_data == SAT_POS_VAL)
    else $error("positive extreme missing");
  sat_neg_a: assert property (s_neg_ovf |=> wb_limited_neg && wb_data == SAT_NEG_VAL)
    else $error("negative extreme missing");
  sat_pass_a: assert property (s_arith_on ##0 (array_result[35] == array_result[32]
    && array_result[32] == array_result[31]) |=> wb_data == $past(array_result))
    else $error("in-range value altered");
  sat_off_a: assert property (instr_valid && !saturation_enable_bit |=> !wb_limited)
    else $error("limited while disabled");
  class_off_a: assert property (instr_valid && instr_class >= MSR_CLS_CMP |=> !wb_limited)
    else $error("limited an excluded class");
  xfer_sat_a: assert property (instr_valid && saturation_enable_bit && instr_class ==
    MSR_CLS_XFER && !xfer_source[35] && (xfer_source[32] || xfer_source[31])
    |=> wb_data == SAT_POS_VAL)
    else $error("transfer not limited");
  round_clear_a: assert property (instr_valid && dest_is_acc && instr_class inside
    {MSR_CLS_RND, MSR_CLS_MPY_RND, MSR_CLS_MAC_RND} |=> wb_data[15:0] ==
    ((wb_limited && !wb_limited_neg) ? SAT_POS_VAL[15:0] : LOW_CLEARED))
    else $error("low word not cleared");
  mode_delay_a: assert property (instr_valid |=> round_mode_active == $past(round_select_bit))
    else $error("rounding mode not taken over");
  cmp_hint_a: assert property (instr_valid && instr_class == MSR_CLS_CMP && saturation_enable_bit
    && cmp_op1_mem_imm && cmp_op2_input_reg |=> cmp_unnorm_sa)
    else $error("compare hint missing");
endmodule : msr_stage_sva

bind msr_stage msr_stage_sva i_msr_stage_sva (.clock(clock), .resetn(resetn),
  .saturation_enable_bit(saturation_enable_bit), .round_select_bit(round_select_bit),
  .instr_valid(instr_valid), .instr_class(instr_class), .dest_is_acc(dest_is_acc),
  .cmp_op1_mem_imm(cmp_op1_mem_imm), .cmp_op2_input_reg(cmp_op2_input_reg),
  .array_result(array_result), .xfer_source(xfer_source), .wb_valid(wb_valid),
  .wb_data(wb_data), .wb_limited(wb_limited), .wb_limited_neg(wb_limited_neg),
  .cmp_unnorm_sa(cmp_unnorm_sa), .round_mode_active(round_mode_active));
